// >>> pkg/omsc_pkg.sv
// Purpose: shared constants and types of the output mute / selector control
// Assumes: 20 MHz internal master clock, 8-bit register address, 32-bit data
// Notes:   volume codes are attenuation in 0.5 dB steps, 8'hff means mute
package omsc_pkg;
    localparam int NCH    = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VOL_W  = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] A_MVOL   = 8'h07;
    localparam logic [ADDR_W-1:0] A_CHVOL0 = 8'h10;
    localparam logic [ADDR_W-1:0] A_CHMUTE = 8'h20;
    localparam logic [ADDR_W-1:0] A_MMUTE  = 8'h21;
    localparam logic [ADDR_W-1:0] A_SUPPLY_VOLUME_CONTROL   = 8'h22;
    localparam logic [ADDR_W-1:0] A_HPCFG  = 8'h23;
    localparam logic [ADDR_W-1:0] A_CH1CFG = 8'h24;
    localparam logic [ADDR_W-1:0] A_CH2CFG = 8'h25;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] A_VOLBQ  = 8'hcf;
    localparam logic [ADDR_W-1:0] A_OMIX   = 8'hd0;
    localparam logic [ADDR_W-1:0] A_SYSCFG = 8'he0;

    // field positions
    localparam int SIXCH_BIT  = 1;
    localparam int REMAP_BIT  = 30;
    localparam int SUPPLY_VOLUME_CONTROL_EN    = 0;
    localparam int SUPPLY_VOLUME_CONTROL_RNG_L = 1;
    localparam int SUPPLY_VOLUME_CONTROL_RNG_H = 2;
    localparam int CHV_IDX_W  = 3;

    // reset values and codes
    localparam logic [VOL_W-1:0]  VOL_MUTE   = 8'hff;
    localparam logic [VOL_W-1:0]  VOL_0DB    = 8'h00;
    localparam logic [DATA_W-1:0] VOLBQ_RST  = 32'h0080_0000;
    localparam logic [DATA_W-1:0] OMIX_RST   = 32'h4000_0000;
    localparam logic [DATA_W-1:0] SYSCFG_RST = 32'h0000_0000;
    localparam logic [NCH-1:0]    LINEOUT_MASK = 8'h30;
    localparam logic [NCH-1:0]    ALL_CH       = 8'hff;

    // supply volume ranges: -12.04, -18.06, -24.08 dB in 0.5 dB steps
    localparam logic [1:0]       RNG_12 = 2'h0;
    localparam logic [1:0]       RNG_18 = 2'h1;
    localparam logic [VOL_W-1:0] LIM_12 = 8'h18;
    localparam logic [VOL_W-1:0] LIM_18 = 8'h24;
    localparam logic [VOL_W-1:0] LIM_24 = 8'h30;

    // timing
    localparam int CLK_NS        = 50;
    localparam int RAMP_NS       = 42600000;
    localparam int RAMP_STEPS    = 255;
    localparam int RAMP_STEP_CYC = RAMP_NS / CLK_NS / RAMP_STEPS;
    localparam int HARD_NS       = 100000;
    localparam int HARD_CYC      = (HARD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 12;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_SOFT   = 2'b01,
        SEQ_HARD   = 2'b11,
        SEQ_UNMUTE = 2'b10
    } omsc_seq_t;
endpackage

// >>> hw/omsc_vol_ramp.sv
// Purpose: one channel's volume ramp toward its target, one code per step
// Assumes: i_step is a single-cycle tick from the same clock
// Notes:   a full mute ramp takes 255 steps
`timescale 1ns/1ps
module omsc_vol_ramp (
    input  wire logic                      i_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_step,
    input  wire logic [omsc_pkg::VOL_W-1:0] i_target,
    output logic      [omsc_pkg::VOL_W-1:0] o_vol,
    output logic                           o_muted
);
    import omsc_pkg::*;

    logic [VOL_W-1:0] vol_reg;
    logic [VOL_W-1:0] vol_next;

    always_comb begin
        vol_next = vol_reg;
        if (i_step && vol_reg < i_target) begin
            vol_next = vol_reg + 8'h01;
        end else if (i_step && vol_reg > i_target) begin
            vol_next = vol_reg - 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            vol_reg <= VOL_MUTE;
        end else begin
            vol_reg <= vol_next;
        end
    end

    assign o_vol   = vol_reg;
    assign o_muted = (vol_reg == VOL_MUTE);

    property p_ramp_smooth;
        @(posedge i_clk) disable iff (!i_nrst)
        (vol_reg != $past(vol_reg)) |-> $past(i_step) &&
            ((vol_reg - $past(vol_reg) == 8'h01) || ($past(vol_reg) - vol_reg == 8'h01));
    endproperty
    a_ramp_smooth: assert property (p_ramp_smooth) else $error("volume jumped");
endmodule // omsc_vol_ramp

// >>> hw/omsc_ctrl.sv
// Purpose: output selector sequencing, master/channel mute and supply volume
// Assumes: register port on the internal clock, pins asynchronous
// Notes:   reads return data the cycle after the read strobe, zero elsewhere
`timescale 1ns/1ps
module omsc_ctrl (
    input  wire logic                         I_CLOCK,
    input  wire logic                         I_NRST,
    input  wire logic [omsc_pkg::ADDR_W-1:0]  I_ADDR,
    input  wire logic [omsc_pkg::DATA_W-1:0]  I_WDATA,
    input  wire logic                         I_WR,
    input  wire logic                         I_RD,
    input  wire logic                         I_SEL_PIN,
    input  wire logic                         I_MUTE_PIN,
    input  wire logic                         I_AM_MUTE,
    input  wire logic                         I_BANK_MUTE,
    input  wire logic                         I_AUTO_MUTE,
    output logic      [omsc_pkg::DATA_W-1:0]  O_RDATA,
    output logic      [omsc_pkg::NCH-1:0]     O_SPK_EN,
    output logic                              O_HP_EN,
    output logic                              O_HP_STOP,
    output logic      [omsc_pkg::NCH-1:0]     O_PWM_HALF,
    output logic      [omsc_pkg::NCH-1:0]     O_PWM_STOP,
    output logic                              O_NS_ON,
    output logic      [omsc_pkg::VOL_W-1:0]   O_CH1_CFG,
    output logic      [omsc_pkg::VOL_W-1:0]   O_CH2_CFG,
    output logic      [omsc_pkg::NCH*8-1:0]   O_CH_VOL,
    output logic                              O_SUPPLY_VOLUME_CONTROL_PWM,
    output logic      [omsc_pkg::DATA_W-1:0]  O_VOLBQ
);
    import omsc_pkg::*;

    // registers
    logic [VOL_W-1:0]  mvol_reg, mvol_next;
    logic [VOL_W-1:0]  chvol_reg [NCH];
    logic [VOL_W-1:0]  chvol_next [NCH];
    logic [NCH-1:0]    chmute_reg, chmute_next;
    logic              mmute_reg, mmute_next;
    logic [2:0]        supply_volume_control_reg, supply_volume_control_next;
    logic [VOL_W-1:0]  hpcfg_reg, hpcfg_next, ch1cfg_reg, ch1cfg_next, ch2cfg_reg, ch2cfg_next;
    logic [DATA_W-1:0] volbq_reg, volbq_next, omix_reg, omix_next, syscfg_reg, syscfg_next;
    logic [DATA_W-1:0] rdata_next;

    // pins: two-flop sync then agreement debounce
    logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_db_reg, pin_db_next;

    // sequencer
    omsc_seq_t         seq_reg, seq_next;
    logic              sel_app_reg, sel_app_next;
    logic [CNT_W-1:0]  hard_cnt_reg, hard_cnt_next;
    logic [CNT_W-1:0]  step_cnt_reg, step_cnt_next;
    logic              step;

    // outputs and channel state
    logic [NCH-1:0]    affected, force_mute, eff_mute, ramp_muted, stop_v;
    logic [VOL_W-1:0]  target [NCH];
    logic [VOL_W-1:0]  vol_now [NCH];
    logic [NCH*8-1:0]  ch_vol_flat;
    logic [VOL_W-1:0]  pwm_cnt_reg, ps_att, ps_lim;
    logic              six_mode, mute_all;

    assign six_mode = syscfg_reg[SIXCH_BIT];
    assign affected = six_mode ? ~LINEOUT_MASK : ALL_CH;
    assign step     = (step_cnt_reg == CNT_W'(RAMP_STEP_CYC - 1));

    // register port
    always_comb begin
        mvol_next   = mvol_reg;
        chmute_next = chmute_reg;
        mmute_next  = mmute_reg;
        supply_volume_control_next   = supply_volume_control_reg;
        hpcfg_next  = hpcfg_reg;
        ch1cfg_next = ch1cfg_reg;
        ch2cfg_next = ch2cfg_reg;
        volbq_next  = volbq_reg;
        omix_next   = omix_reg;
        syscfg_next = syscfg_reg;
        for (int i = 0; i < NCH; i++) begin
            chvol_next[i] = chvol_reg[i];
        end
        if (I_WR) begin
            if (I_ADDR[ADDR_W-1:CHV_IDX_W] == A_CHVOL0[ADDR_W-1:CHV_IDX_W]) begin
                chvol_next[I_ADDR[CHV_IDX_W-1:0]] = I_WDATA[VOL_W-1:0];
            end
            unique case (I_ADDR)
                A_MVOL:   mvol_next   = I_WDATA[VOL_W-1:0];
                A_CHMUTE: chmute_next = I_WDATA[NCH-1:0];
                A_MMUTE:  mmute_next  = I_WDATA[0];
                A_SUPPLY_VOLUME_CONTROL:   supply_volume_control_next   = I_WDATA[SUPPLY_VOLUME_CONTROL_RNG_H:0];
                A_HPCFG:  hpcfg_next  = I_WDATA[VOL_W-1:0];
                A_CH1CFG: ch1cfg_next = I_WDATA[VOL_W-1:0];
                A_CH2CFG: ch2cfg_next = I_WDATA[VOL_W-1:0];
                A_VOLBQ:  volbq_next  = I_WDATA;
                A_OMIX:   omix_next   = I_WDATA;
                A_SYSCFG: syscfg_next = I_WDATA;
                default:  ;
            endcase
        end
        rdata_next = '0;
        if (I_RD) begin
            if (I_ADDR[ADDR_W-1:CHV_IDX_W] == A_CHVOL0[ADDR_W-1:CHV_IDX_W]) begin
                rdata_next = {24'h0, chvol_reg[I_ADDR[CHV_IDX_W-1:0]]};
            end
            unique case (I_ADDR)
                A_MVOL:   rdata_next = {24'h0, mvol_reg};
                A_CHMUTE: rdata_next = {24'h0, chmute_reg};
                A_MMUTE:  rdata_next = {31'h0, mmute_reg};
                A_SUPPLY_VOLUME_CONTROL:   rdata_next = {29'h0, supply_volume_control_reg};
                A_HPCFG:  rdata_next = {24'h0, hpcfg_reg};
                A_CH1CFG: rdata_next = {24'h0, ch1cfg_reg};
                A_CH2CFG: rdata_next = {24'h0, ch2cfg_reg};
                A_STATUS: rdata_next = {16'h0, eff_mute, 3'h0, seq_reg, sel_app_reg, pin_db_reg};
                A_VOLBQ:  rdata_next = volbq_reg;
                A_OMIX:   rdata_next = omix_reg;
                A_SYSCFG: rdata_next = syscfg_reg;
                default:  ;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            mvol_reg   <= VOL_MUTE;
            chmute_reg <= '0;
            mmute_reg  <= 1'b0;
            supply_volume_control_reg   <= '0;
            hpcfg_reg  <= '0;
            ch1cfg_reg <= '0;
            ch2cfg_reg <= '0;
            volbq_reg  <= VOLBQ_RST;
            omix_reg   <= OMIX_RST;
            syscfg_reg <= SYSCFG_RST;
            O_RDATA    <= '0;
            for (int i = 0; i < NCH; i++) begin
                chvol_reg[i] <= VOL_0DB;
            end
        end else begin
            mvol_reg   <= mvol_next;
            chmute_reg <= chmute_next;
            mmute_reg  <= mmute_next;
            supply_volume_control_reg   <= supply_volume_control_next;
            hpcfg_reg  <= hpcfg_next;
            ch1cfg_reg <= ch1cfg_next;
            ch2cfg_reg <= ch2cfg_next;
            volbq_reg  <= volbq_next;
            omix_reg   <= omix_next;
            syscfg_reg <= syscfg_next;
            O_RDATA    <= rdata_next;
            for (int i = 0; i < NCH; i++) begin
                chvol_reg[i] <= chvol_next[i];
            end
        end
    end

    // pin conditioning: bit 0 selector, bit 1 mute
    always_comb begin
        pin_db_next = pin_db_reg;
        for (int b = 0; b < 2; b++) begin
            if (pin_s2_reg[b] == pin_s3_reg[b]) begin
                pin_db_next[b] = pin_s2_reg[b];
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            pin_db_reg <= '0;
        end else begin
            pin_s1_reg <= {I_MUTE_PIN, I_SEL_PIN};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_db_reg <= pin_db_next;
        end
    end

    // selector sequence; the new selection takes effect only under hard mute
    always_comb begin
        seq_next      = seq_reg;
        sel_app_next  = sel_app_reg;
        hard_cnt_next = '0;
        step_cnt_next = step ? '0 : step_cnt_reg + CNT_W'(1);
        unique case (seq_reg)
            SEQ_IDLE: begin
                if (pin_db_reg[0] != sel_app_reg) begin
                    seq_next = SEQ_SOFT;
                end
            end
            SEQ_SOFT: begin
                if (&(ramp_muted | ~affected)) begin
                    seq_next = SEQ_HARD;
                end
            end
            SEQ_HARD: begin
                hard_cnt_next = hard_cnt_reg + CNT_W'(1);
                if (hard_cnt_reg == CNT_W'(HARD_CYC - 1)) begin
                    sel_app_next = pin_db_reg[0];
                    seq_next     = SEQ_UNMUTE;
                end
            end
            SEQ_UNMUTE: seq_next = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            seq_reg      <= SEQ_IDLE;
            sel_app_reg  <= 1'b0;
            hard_cnt_reg <= '0;
            step_cnt_reg <= '0;
        end else begin
            seq_reg      <= seq_next;
            sel_app_reg  <= sel_app_next;
            hard_cnt_reg <= hard_cnt_next;
            step_cnt_reg <= step_cnt_next;
        end
    end

    // mute merge: any mute source wins over volume; volume writes still land
    assign mute_all   = pin_db_reg[1] | mmute_reg | I_AM_MUTE | I_BANK_MUTE | I_AUTO_MUTE
                      | (mvol_reg == VOL_MUTE);
    assign force_mute = (seq_reg == SEQ_SOFT || seq_reg == SEQ_HARD) ? affected : '0;
    assign eff_mute   = {NCH{mute_all}} | chmute_reg | force_mute;
    assign stop_v     = (seq_reg == SEQ_HARD) ? affected : '0;

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            logic [VOL_W:0] sum;
            assign sum = {1'b0, mvol_reg} + {1'b0, chvol_reg[g]};
            assign target[g] = (eff_mute[g] || sum[VOL_W] || sum[VOL_W-1:0] == VOL_MUTE)
                             ? VOL_MUTE : sum[VOL_W-1:0];
            omsc_vol_ramp u_ramp (
                .i_clk    (I_CLOCK),
                .i_nrst   (I_NRST),
                .i_step   (step),
                .i_target (target[g]),
                .o_vol    (vol_now[g]),
                .o_muted  (ramp_muted[g])
            );
            assign ch_vol_flat[g*8 +: 8] = vol_now[g];
        end
    endgenerate

    // supply volume reference follows master volume, clamped to the range
    always_comb begin
        unique case (supply_volume_control_reg[SUPPLY_VOLUME_CONTROL_RNG_H:SUPPLY_VOLUME_CONTROL_RNG_L])
            RNG_12:  ps_lim = LIM_12;
            RNG_18:  ps_lim = LIM_18;
            default: ps_lim = LIM_24;
        endcase
        ps_att = (mvol_reg > ps_lim) ? ps_lim : mvol_reg;
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            pwm_cnt_reg <= '0;
            O_SPK_EN    <= '0;
            O_HP_EN     <= 1'b0;
            O_HP_STOP   <= 1'b0;
            O_PWM_HALF  <= '0;
            O_PWM_STOP  <= '0;
            O_NS_ON     <= 1'b0;
            O_CH1_CFG   <= '0;
            O_CH2_CFG   <= '0;
            O_CH_VOL    <= {NCH{VOL_MUTE}};
            O_SUPPLY_VOLUME_CONTROL_PWM  <= 1'b0;
            O_VOLBQ     <= VOLBQ_RST;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
            O_SPK_EN    <= sel_app_reg ? ALL_CH : (six_mode ? LINEOUT_MASK : '0);
            O_HP_EN     <= ~sel_app_reg;
            O_HP_STOP   <= (seq_reg == SEQ_HARD);
            O_PWM_HALF  <= ramp_muted & ~stop_v;
            O_PWM_STOP  <= stop_v;
            O_NS_ON     <= (seq_reg == SEQ_SOFT);
            O_CH1_CFG   <= sel_app_reg ? ch1cfg_reg : hpcfg_reg;
            O_CH2_CFG   <= sel_app_reg ? ch2cfg_reg : hpcfg_reg;
            O_CH_VOL    <= ch_vol_flat;
            O_SUPPLY_VOLUME_CONTROL_PWM  <= supply_volume_control_reg[SUPPLY_VOLUME_CONTROL_EN] && (pwm_cnt_reg < ~ps_att);
            O_VOLBQ     <= volbq_reg;
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);

    property p_sel_enables;
        $past(I_NRST) && seq_reg == SEQ_IDLE ##1 seq_reg == SEQ_IDLE
            |-> (O_HP_EN == ~sel_app_reg) && (O_SPK_EN[0] == sel_app_reg);
    endproperty
    a_sel_enables: assert property (p_sel_enables) else $error("enable mismatch");
    property p_hard_after_soft;
        $rose(seq_reg == SEQ_HARD) |-> $past(seq_reg) == SEQ_SOFT && &(ramp_muted | ~affected) [*1]
            ##0 (seq_reg == SEQ_HARD) [*8];
    endproperty
    a_hard_after_soft: assert property (p_hard_after_soft) else $error("bad mute order");
    property p_lineout_free;
        six_mode && $stable(six_mode) |=> O_PWM_STOP[5:4] == 2'b00 && O_SPK_EN[5:4] == 2'b11;
    endproperty
    a_lineout_free: assert property (p_lineout_free) else $error("lineout disturbed");
    property p_cfg_select;
        !sel_app_reg && $stable(hpcfg_reg) && $stable(sel_app_reg) |=> O_CH1_CFG == $past(hpcfg_reg);
    endproperty
    a_cfg_select: assert property (p_cfg_select) else $error("ch1 cfg wrong");
    property p_master_mute;
        (mmute_reg || pin_db_reg[1]) |-> target[0] == VOL_MUTE && target[7] == VOL_MUTE;
    endproperty
    a_master_mute: assert property (p_master_mute) else $error("master mute ignored");
    property p_other_mutes;
        (I_AM_MUTE || I_BANK_MUTE || I_AUTO_MUTE) |-> &eff_mute;
    endproperty
    a_other_mutes: assert property (p_other_mutes) else $error("mute overridden");
    property p_chan_only;
        !mute_all && seq_reg == SEQ_IDLE && chmute_reg == 8'h01 |-> eff_mute == 8'h01;
    endproperty
    a_chan_only: assert property (p_chan_only) else $error("channel mute leaked");
    property p_half_duty;
        $past(I_NRST) && ramp_muted[2] && !stop_v[2] |=> O_PWM_HALF[2];
    endproperty
    a_half_duty: assert property (p_half_duty) else $error("muted pwm not at half");
    property p_last_volume;
        !eff_mute[3] && {1'b0, mvol_reg} + {1'b0, chvol_reg[3]} < {1'b0, VOL_MUTE} |-> target[3] == mvol_reg + chvol_reg[3];
    endproperty
    a_last_volume: assert property (p_last_volume) else $error("volume not restored");
    property p_supply_volume_control_off;
        !supply_volume_control_reg[SUPPLY_VOLUME_CONTROL_EN] |=> !O_SUPPLY_VOLUME_CONTROL_PWM;
    endproperty
    a_supply_volume_control_off: assert property (p_supply_volume_control_off) else $error("supply pwm while off");
    property p_supply_volume_control_range;
        supply_volume_control_reg[SUPPLY_VOLUME_CONTROL_RNG_H:SUPPLY_VOLUME_CONTROL_RNG_L] == RNG_12 |-> ps_att <= LIM_12;
    endproperty
    a_supply_volume_control_range: assert property (p_supply_volume_control_range) else $error("supply range exceeded");
    property p_reset_mute;
        mvol_reg == VOL_MUTE |-> target[1] == VOL_MUTE;
    endproperty
    a_reset_mute: assert property (p_reset_mute) else $error("unmuted at mute volume");
    property p_debounce;
        $changed(pin_db_reg[0]) |-> $past(pin_s2_reg[0]) == $past(pin_s3_reg[0]);
    endproperty
    a_debounce: assert property (p_debounce) else $error("selector not debounced");

    c_hard:   cover property ($rose(seq_reg == SEQ_HARD));
    c_swap:   cover property (seq_reg == SEQ_UNMUTE && sel_app_reg);
    c_supply_volume_control:   cover property ($rose(O_SUPPLY_VOLUME_CONTROL_PWM));
    c_unmute: cover property ($fell(ramp_muted[0]));
endmodule // omsc_ctrl

// >>> dv/omsc_host.sv
// Purpose: controller-side model that drives the selector and mute pins
// Assumes: requests come from the bench on the internal clock
// Notes:   pins move only just after an edge, like a controller's port
`timescale 1ns/1ps
module omsc_host (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_sel_req,
    input  wire logic i_mute_req,
    output logic      o_sel_pin,
    output logic      o_mute_pin
);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sel_pin  <= 1'b0;
            o_mute_pin <= 1'b0;
        end else begin
            o_sel_pin  <= i_sel_req;
            o_mute_pin <= i_mute_req;
        end
    end
endmodule // omsc_host

// >>> dv/omsc_ctrl_tb.sv
// Purpose: self-checking bench for the output mute / selector control
// Assumes: ramps run from mute to a code near mute to keep the run short
// Notes:   read results are checked from a queue by a watcher process
`timescale 1ns/1ps
module omsc_ctrl_tb;
    import omsc_pkg::*;
    logic              clk, nrst, wr, rd, rd_d, sel_req, mute_req, sel_pin, mute_pin, hp_en, hp_stop, ns_on, supply_volume_control_pwm;
    logic [2:0]        side_mute;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, volbq, seed;
    logic [NCH-1:0]    spk_en, pwm_half, pwm_stop;
    logic [VOL_W-1:0]  ch1_cfg, ch2_cfg, hp, c1, c2;
    logic [NCH*8-1:0]  ch_vol;
    logic [DATA_W-1:0] exp_q[$];
    int                num_errors, check_count, n, k;

    omsc_host host (.i_clk(clk), .i_nrst(nrst), .i_sel_req(sel_req), .i_mute_req(mute_req),
        .o_sel_pin(sel_pin), .o_mute_pin(mute_pin));
    omsc_ctrl uut (.I_CLOCK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .I_SEL_PIN(sel_pin), .I_MUTE_PIN(mute_pin), .I_AM_MUTE(side_mute[0]),
        .I_BANK_MUTE(side_mute[1]), .I_AUTO_MUTE(side_mute[2]), .O_RDATA(rdata),
        .O_SPK_EN(spk_en), .O_HP_EN(hp_en), .O_HP_STOP(hp_stop), .O_PWM_HALF(pwm_half),
        .O_PWM_STOP(pwm_stop), .O_NS_ON(ns_on), .O_CH1_CFG(ch1_cfg), .O_CH2_CFG(ch2_cfg),
        .O_CH_VOL(ch_vol), .O_SUPPLY_VOLUME_CONTROL_PWM(supply_volume_control_pwm), .O_VOLBQ(volbq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a wait that ran out of cycles ends the run at once
    task automatic bound(input int lim);
        if (n >= lim) begin
            num_errors++;
            $display("unexpected at %0t: waited %h limit %h", $time, n, lim);
            give_verdict();
        end
    endtask
    task automatic acc(input int w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        wr <= (w != 0);
        rd <= (w == 0);
        addr <= a;
        wdata <= d;
        if (w == 0) exp_q.push_back(d);
        @(posedge clk);
    endtask
    task automatic idle(input int c);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (c) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
    end

    initial begin
        {nrst, wr, rd, sel_req, mute_req, side_mute, addr, wdata} = '0;
        seed = 32'd93;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(ch_vol, {NCH{VOL_MUTE}});
        chk(volbq, VOLBQ_RST);
        chk({spk_en, hp_en}, 9'h001);
        acc(0, A_MVOL, 32'hff);
        acc(0, A_VOLBQ, VOLBQ_RST);
        acc(0, 8'h99, 32'h0);
        acc(1, A_SYSCFG, 32'h2);
        acc(0, A_SYSCFG, 32'h2);
        acc(1, A_SUPPLY_VOLUME_CONTROL, 32'h3);
        acc(0, A_SUPPLY_VOLUME_CONTROL, 32'h3);
        acc(1, A_SUPPLY_VOLUME_CONTROL, 32'h5);
        acc(0, A_SUPPLY_VOLUME_CONTROL, 32'h5);
        seed = xs(seed);
        hp = seed[7:0];
        c1 = seed[15:8];
        c2 = seed[23:16];
        acc(1, A_HPCFG, {24'h0, hp});
        acc(1, A_CH1CFG, {24'h0, c1});
        acc(1, A_CH2CFG, {24'h0, c2});
        acc(1, A_VOLBQ, seed);
        acc(1, A_MVOL, 32'hfa);
        idle(2);
        chk({ch1_cfg, ch2_cfg}, {hp, hp});
        chk(volbq, seed);
        for (n = 0; n < 20000 && ch_vol !== {NCH{8'hfa}}; n++) @(posedge clk);
        bound(20000);
        chk(pwm_half, 8'h00);
        k = 0;
        repeat (256) begin
            @(posedge clk);
            k += supply_volume_control_pwm;
        end
        chk(k, 8'hff - LIM_24);
        acc(1, A_CHMUTE, 32'h1);
        acc(1, A_CHVOL0, 32'h2);
        idle(1);
        for (n = 0; n < 20000 && ch_vol[7:0] !== VOL_MUTE; n++) @(posedge clk);
        bound(20000);
        chk(ch_vol, {{7{8'hfa}}, VOL_MUTE});
        chk(pwm_half, 8'h01);
        acc(1, A_CHMUTE, 32'h0);
        idle(1);
        for (n = 0; n < 15000 && ch_vol[7:0] !== 8'hfc; n++) @(posedge clk);
        bound(15000);
        chk(ch_vol, {{7{8'hfa}}, 8'hfc});
        mute_req <= 1'b1;
        for (n = 0; n < 20000 && ch_vol !== {NCH{VOL_MUTE}}; n++) @(posedge clk);
        bound(20000);
        chk(pwm_half, ALL_CH);
        acc(1, A_MVOL, 32'hf0);
        acc(0, A_STATUS, 32'h0000_ff02);
        for (k = 0; k < 3; k++) begin
            mute_req <= 1'b0;
            side_mute <= 3'b001 << k;
            idle(8);
            acc(0, A_STATUS, 32'h0000_ff00);
        end
        mute_req <= 1'b1;
        idle(8);
        side_mute <= 3'b000;
        acc(1, A_SYSCFG, 32'h0);
        sel_req <= 1'b1;
        idle(1);
        k = 0;
        for (n = 0; n < 20000 && pwm_stop === 8'h00; n++) begin
            @(posedge clk);
            k = k | ns_on;
        end
        bound(20000);
        chk({pwm_stop, spk_en, hp_en, hp_stop}, {ALL_CH, 8'h00, 1'b1, 1'b1});
        chk(k, 1);
        for (n = 0; n < 3000 && hp_en !== 1'b0; n++) @(posedge clk);
        bound(3000);
        chk({spk_en, ch1_cfg, ch2_cfg}, {ALL_CH, c1, c2});
        acc(1, A_SYSCFG, 32'h2);
        sel_req <= 1'b0;
        idle(1);
        k = 0;
        for (n = 0; n < 20000 && pwm_stop === 8'h00; n++) begin
            @(posedge clk);
            k = k | ns_on;
        end
        bound(20000);
        chk({pwm_stop, hp_stop}, {~LINEOUT_MASK, 1'b1});
        chk(k, 1);
        for (n = 0; n < 3000 && hp_en !== 1'b1; n++) @(posedge clk);
        bound(3000);
        chk({spk_en, ch1_cfg, ch2_cfg}, {LINEOUT_MASK, hp, hp});
        idle(3);
        give_verdict();
    end
endmodule // omsc_ctrl_tb
